// File: rtl/ppio_pkg.sv
// Purpose: shared constants for the parallel-io host controller
// Assumes: 20 MHz system clock, one parallel_io_device on the pins
// Notes: device timing figures are plain defaults, tune per board
package ppio_pkg;
  localparam int CLK_MHZ = 20;
  // device addresses on addr_sel_hi/addr_sel_lo
  localparam logic [1:0] DEV_PORT_A = 2'h0;
  localparam logic [1:0] DEV_PORT_B = 2'h1;
  localparam logic [1:0] DEV_PORT_C = 2'h2;
  localparam logic [1:0] DEV_CTRL = 2'h3;
  // control word layout
  localparam int CW_MODE_BIT = 7;
  localparam int BSR_SEL_LSB = 1;
  localparam int BSR_SEL_MSB = 3;
  localparam int BSR_VAL_BIT = 0;
  localparam int DIR_A_BIT = 4;
  localparam int DIR_CU_BIT = 3;
  localparam int DIR_B_BIT = 1;
  localparam int DIR_CL_BIT = 0;
  localparam int INTERRUPT_ENABLE_FLAG_A_IN_BIT = 4;
  localparam int INTERRUPT_ENABLE_FLAG_A_OUT_BIT = 6;
  localparam int INTERRUPT_ENABLE_FLAG_B_BIT = 2;
  // own registers, byte offsets on AHB-Lite
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h0C;
  localparam logic [7:0] REG_BSR = 8'h10;
  localparam logic [7:0] REG_CTL = 8'h14;
  // CMD fields
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ_BIT = 12;
  // STAT fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_IRQ_A = 4;
  localparam int ST_IRQ_B = 5;
  localparam int ST_MODE_VALID = 7;
  localparam int ST_DIR_LSB = 8;
  localparam int ST_INTERRUPT_ENABLE_FLAG_LSB = 12;
  // bus cycle timing
  localparam int T_SETUP_NS = 100;
  localparam int T_STROBE_NS = 300;
  localparam int T_HOLD_NS = 50;
  localparam int T_RECOVER_NS = 200;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_CYC = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
endpackage

// File: rtl/ppio_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: bits are independent levels
// Notes: multi-bit words are only sampled once stable
`timescale 1ns/1ps
module ppio_sync2 #(
  parameter int W = 8
) (
  input wire logic clk_sys_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [W-1:0] d_in, // async input
  output logic [W-1:0] q_out // synchronised output
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
  assign q_out = q_r;
endmodule

// File: rtl/ppio_bus_seq.sv
// Purpose: one read or write cycle on the device's chip-select bus
// Assumes: dbus_sync_in already passed two flops
// Notes: strobe must cover sync delay plus device access time
`timescale 1ns/1ps
module ppio_bus_seq #(
  parameter int SETUP_CYC = ppio_pkg::SETUP_CYC,
  parameter int STROBE_CYC = ppio_pkg::STROBE_CYC,
  parameter int HOLD_CYC = ppio_pkg::HOLD_CYC,
  parameter int RECOVER_CYC = ppio_pkg::RECOVER_CYC
) (
  input wire logic clk_sys_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic start_in, // one-cycle start pulse
  input wire logic rd_in, // 1 read, 0 write
  input wire logic [1:0] addr_in, // device address
  input wire logic [7:0] wdata_in, // write byte
  input wire logic [7:0] dbus_sync_in, // synchronised data bus
  output logic busy_out, // cycle in progress
  output logic done_out, // one-cycle end pulse
  output logic [7:0] rdata_out, // captured read byte
  output logic cs_n_out, // chip select, active low
  output logic rd_n_out, // read strobe, active low
  output logic wr_n_out, // write strobe, active low
  output logic [1:0] addr_out, // addr_sel_hi, addr_sel_lo
  output logic [7:0] dbus_out, // data bus drive value
  output logic dbus_oe_out // data bus drive enable
);
  if (SETUP_CYC < 1 || STROBE_CYC < 3 || HOLD_CYC < 1 || RECOVER_CYC < 1 ||
      STROBE_CYC > 15 || SETUP_CYC > 15 || HOLD_CYC > 15 || RECOVER_CYC > 15) begin : g_bad
    $error("ppio_bus_seq: timing counts out of range");
  end
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STB, S_HOLD, S_RCV} ppio_seq_e;
  ppio_seq_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rd_r, cs_n_r, rd_n_r, wr_n_r, oe_r, done_r;
  logic [1:0] addr_r;
  logic [7:0] wdata_r, rdata_r;
  wire last_w = (cnt_r == 4'h1);
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r - 4'h1;
    case (state_r)
      S_IDLE: begin
        cnt_nxt = 4'(SETUP_CYC);
        if (start_in) state_nxt = S_SETUP;
      end
      S_SETUP: if (last_w) begin
        state_nxt = S_STB;
        cnt_nxt = 4'(STROBE_CYC);
      end
      S_STB: if (last_w) begin
        state_nxt = S_HOLD;
        cnt_nxt = 4'(HOLD_CYC);
      end
      S_HOLD: if (last_w) begin
        state_nxt = S_RCV;
        cnt_nxt = 4'(RECOVER_CYC);
      end
      S_RCV: if (last_w) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end
  // bus floats and cs_n high outside a cycle
  wire cs_n_nxt = (state_nxt == S_IDLE) || (state_nxt == S_RCV);
  wire rd_n_nxt = !((state_nxt == S_STB) && rd_r);
  wire wr_n_nxt = !((state_nxt == S_STB) && !rd_r);
  wire oe_nxt = !rd_r && ((state_nxt == S_STB) || (state_nxt == S_HOLD));
  wire cap_w = (state_r == S_STB) && last_w && rd_r;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b1;
      addr_r <= 2'h0;
      wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (state_r == S_IDLE && start_in) begin
        rd_r <= rd_in;
        addr_r <= addr_in;
        wdata_r <= wdata_in;
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      oe_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      cs_n_r <= cs_n_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      oe_r <= oe_nxt;
      done_r <= (state_r == S_RCV) && last_w;
      if (cap_w) rdata_r <= dbus_sync_in;
    end
  end
  assign busy_out = (state_r != S_IDLE);
  assign done_out = done_r;
  assign rdata_out = rdata_r;
  assign cs_n_out = cs_n_r;
  assign rd_n_out = rd_n_r;
  assign wr_n_out = wr_n_r;
  assign addr_out = addr_r;
  assign dbus_out = wdata_r;
  assign dbus_oe_out = oe_r;

  // helper: length of each read strobe
  logic [3:0] rd_low_cnt_r;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) rd_low_cnt_r <= 4'h0;
    else if (!rd_n_r) rd_low_cnt_r <= rd_low_cnt_r + 4'h1;
    else rd_low_cnt_r <= 4'h0;
  end
  AST_ONE_STROBE: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !(!rd_n_out && !wr_n_out)) else $error("read and write strobes low together");
  AST_FLOAT_IDLE: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    cs_n_out |-> (rd_n_out && wr_n_out && !dbus_oe_out)) else $error("bus active without cs");
  AST_NO_CTRL_READ: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !rd_n_out |-> (addr_out != ppio_pkg::DEV_CTRL)) else $error("read at control address");
  AST_STB_WIDTH: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $rose(rd_n_out) |-> (rd_low_cnt_r == 4'(STROBE_CYC))) else $error("read strobe width wrong");
endmodule

// File: rtl/ppio_host_ctrl.sv
// Purpose: AHB-Lite programmable host that drives a parallel-io device
// Assumes: device pins wired directly, reset pin active high
// Notes: control word is write-only, so the last mode word is shadowed
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ppio_host_ctrl (
  input wire logic clk_sys_in, // 20 MHz system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic hsel_in, // AHB slave select
  input wire logic [7:0] haddr_in, // AHB byte address
  input wire logic [1:0] htrans_in, // AHB transfer type
  input wire logic hwrite_in, // AHB write
  input wire logic [2:0] hsize_in, // AHB size, word only
  input wire logic [31:0] hwdata_in, // AHB write data
  input wire logic hready_in, // AHB bus ready
  output logic hreadyout_out, // AHB slave ready
  output logic [31:0] hrdata_out, // AHB read data
  output logic hresp_out, // AHB response, always OKAY
  output logic dev_cs_n_out, // device chip select
  output logic dev_rd_n_out, // device read strobe
  output logic dev_wr_n_out, // device write strobe
  output logic addr_sel_lo_out, // device address bit 0
  output logic addr_sel_hi_out, // device address bit 1
  input wire logic [7:0] dev_data_in, // device data bus level
  output logic [7:0] dev_data_out, // device data drive value
  output logic dev_data_oe_out, // device data drive enable
  output logic dev_reset_out, // device reset, active high
  input wire logic irq_a_in, // group A interrupt_request pin
  input wire logic irq_b_in // group B interrupt_request pin
);
  // AHB address phase capture
  logic wr_ph_r;
  logic [7:0] addr_ph_r;
  logic [31:0] hrdata_r;
  // own state
  logic done_r, refused_r, soft_reset_r, dev_reset_r;
  logic [7:0] mode_shadow_r, pc_shadow_r;
  logic start_r, start_rd_r;
  logic [1:0] start_addr_r;
  logic [7:0] start_wdata_r;
  logic busy_w, done_w;
  logic [7:0] rdata_w, dbus_sync_w;
  logic [1:0] irq_sync_w;
  logic [1:0] dev_addr_w;

  wire addr_ok_w = hsel_in && hready_in && htrans_in[1];
  wire wr_w = wr_ph_r;
  wire wr_cmd_w = wr_w && (addr_ph_r == ppio_pkg::REG_CMD);
  wire wr_stat_w = wr_w && (addr_ph_r == ppio_pkg::REG_STAT);
  wire wr_mode_w = wr_w && (addr_ph_r == ppio_pkg::REG_MODE);
  wire wr_bsr_w = wr_w && (addr_ph_r == ppio_pkg::REG_BSR);
  wire wr_ctl_w = wr_w && (addr_ph_r == ppio_pkg::REG_CTL);
  wire [1:0] cmd_addr_w = hwdata_in[ppio_pkg::CMD_ADDR_LSB +: 2];
  wire cmd_rd_w = hwdata_in[ppio_pkg::CMD_READ_BIT];
  // bus occupied, or device held in reset
  wire blocked_w = busy_w || start_r || dev_reset_r;
  // the control word cannot be read, so such a request is turned away
  wire bad_read_w = wr_cmd_w && cmd_rd_w && (cmd_addr_w == ppio_pkg::DEV_CTRL);
  wire issue_req_w = wr_cmd_w || wr_mode_w || wr_bsr_w;
  wire refuse_w = issue_req_w && (blocked_w || bad_read_w);
  wire issue_w = issue_req_w && !refuse_w;
  // mode word: bit 7 forced high, low seven bits as written
  wire [7:0] mode_word_w = {1'b1, hwdata_in[6:0]};
  // set/reset word: bit 7 low, selected bit and value
  wire [2:0] bsr_sel_w = hwdata_in[2:0];
  wire bsr_val_w = hwdata_in[3];
  wire [7:0] bsr_word_w = {4'h0, bsr_sel_w, bsr_val_w};
  wire [7:0] issue_word_w = wr_mode_w ? mode_word_w :
                            (wr_bsr_w ? bsr_word_w : hwdata_in[7:0]);
  wire [1:0] issue_addr_w = wr_cmd_w ? cmd_addr_w : ppio_pkg::DEV_CTRL;
  wire issue_rd_w = wr_cmd_w && cmd_rd_w;
  wire done_clr_w = wr_stat_w && hwdata_in[ppio_pkg::ST_DONE];
  wire ref_clr_w = wr_stat_w && hwdata_in[ppio_pkg::ST_REFUSED];
  wire mode_valid_w = mode_shadow_r[ppio_pkg::CW_MODE_BIT];
  // directions as last programmed, one means input
  wire [3:0] dir_w = {mode_shadow_r[ppio_pkg::DIR_A_BIT],
                      mode_shadow_r[ppio_pkg::DIR_CU_BIT],
                      mode_shadow_r[ppio_pkg::DIR_B_BIT],
                      mode_shadow_r[ppio_pkg::DIR_CL_BIT]};
  // interrupt enables follow the set/reset commands sent to port C
  wire [2:0] interrupt_enable_flag_w = {pc_shadow_r[ppio_pkg::INTERRUPT_ENABLE_FLAG_A_OUT_BIT],
                       pc_shadow_r[ppio_pkg::INTERRUPT_ENABLE_FLAG_A_IN_BIT],
                       pc_shadow_r[ppio_pkg::INTERRUPT_ENABLE_FLAG_B_BIT]};
  wire [31:0] stat_w = {16'h0000, 1'b0, interrupt_enable_flag_w, dir_w, mode_valid_w, 1'b0,
                        irq_sync_w[1], irq_sync_w[0], 1'b0, refused_r, done_r,
                        busy_w || start_r};
  wire [31:0] rdmux_w = (haddr_in == ppio_pkg::REG_STAT) ? stat_w :
                        (haddr_in == ppio_pkg::REG_RDATA) ? {16'h0000, pc_shadow_r, rdata_w} :
                        (haddr_in == ppio_pkg::REG_MODE) ? {24'h000000, mode_shadow_r} :
                        (haddr_in == ppio_pkg::REG_CTL) ? {31'h00000000, soft_reset_r} :
                        32'h00000000;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ph_r <= 1'b0;
      addr_ph_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else if (hready_in) begin
      wr_ph_r <= addr_ok_w && hwrite_in;
      addr_ph_r <= haddr_in;
      hrdata_r <= (addr_ok_w && !hwrite_in) ? rdmux_w : 32'h00000000;
    end
  end

  // set wins over clear on both sticky flags
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      done_r <= done_w || (done_r && !done_clr_w);
      refused_r <= refuse_w || (refused_r && !ref_clr_w);
    end
  end

  // device reset pin follows system reset or software request
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_reset_r <= 1'b0;
      dev_reset_r <= 1'b1;
    end else begin
      if (wr_ctl_w) soft_reset_r <= hwdata_in[0];
      dev_reset_r <= wr_ctl_w ? hwdata_in[0] : soft_reset_r;
    end
  end

  // shadows are cleared with the device so they never claim stale modes
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_shadow_r <= 8'h00;
      pc_shadow_r <= 8'h00;
    end else if (dev_reset_r) begin
      mode_shadow_r <= 8'h00;
      pc_shadow_r <= 8'h00;
    end else if (issue_w && wr_mode_w) begin
      mode_shadow_r <= mode_word_w;
      pc_shadow_r <= 8'h00;
    end else if (issue_w && wr_bsr_w) begin
      pc_shadow_r[bsr_sel_w] <= bsr_val_w;
    end else if (issue_w && wr_cmd_w && !cmd_rd_w && cmd_addr_w == ppio_pkg::DEV_PORT_C) begin
      pc_shadow_r <= hwdata_in[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_r <= 1'b0;
      start_rd_r <= 1'b1;
      start_addr_r <= 2'h0;
      start_wdata_r <= 8'h00;
    end else begin
      start_r <= issue_w;
      if (issue_w) begin
        start_rd_r <= issue_rd_w;
        start_addr_r <= issue_addr_w;
        start_wdata_r <= issue_word_w;
      end
    end
  end

  ppio_sync2 #(.W(8)) u_sync_data (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .d_in(dev_data_in),
    .q_out(dbus_sync_w)
  );

  // interrupt pins are raised and dropped by the device itself
  ppio_sync2 #(.W(2)) u_sync_irq (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .d_in({irq_b_in, irq_a_in}),
    .q_out(irq_sync_w)
  );

  ppio_bus_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .start_in(start_r),
    .rd_in(start_rd_r),
    .addr_in(start_addr_r),
    .wdata_in(start_wdata_r),
    .dbus_sync_in(dbus_sync_w),
    .busy_out(busy_w),
    .done_out(done_w),
    .rdata_out(rdata_w),
    .cs_n_out(dev_cs_n_out),
    .rd_n_out(dev_rd_n_out),
    .wr_n_out(dev_wr_n_out),
    .addr_out(dev_addr_w),
    .dbus_out(dev_data_out),
    .dbus_oe_out(dev_data_oe_out)
  );

  assign addr_sel_lo_out = dev_addr_w[0];
  assign addr_sel_hi_out = dev_addr_w[1];
  assign dev_reset_out = dev_reset_r;
  assign hreadyout_out = 1'b1;
  assign hrdata_out = hrdata_r;
  assign hresp_out = 1'b0;

  // checks
  sequence seq_issue_mode;
    issue_w && wr_mode_w;
  endsequence
  sequence seq_issue_bsr;
    issue_w && wr_bsr_w;
  endsequence
  sequence seq_start_write_ctrl;
    start_r && !start_rd_r && (start_addr_r == ppio_pkg::DEV_CTRL);
  endsequence

  AST_MODE_WORD: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    seq_issue_mode |=> seq_start_write_ctrl ##0 start_wdata_r[ppio_pkg::CW_MODE_BIT])
    else $error("mode word sent without bit 7 set");
  AST_BSR_WORD: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    seq_issue_bsr |=> seq_start_write_ctrl ##0
    (start_wdata_r == {4'h0, $past(hwdata_in[2:0]), $past(hwdata_in[3])}))
    else $error("set/reset word malformed");
  AST_REFUSE_CTRL_READ: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    bad_read_w |=> (refused_r && !start_r)) else $error("control read not refused");
  AST_DEV_RESET: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_ctl_w && hwdata_in[0]) |=> dev_reset_out ##1 (mode_shadow_r == 8'h00))
    else $error("device reset not applied");
  AST_CYCLE_DONE: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    start_r |-> ##[10:70] done_w) else $error("bus cycle never finished");
  AST_PC_SHADOW: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (seq_issue_bsr ##0 !dev_reset_r) |=> (pc_shadow_r[$past(bsr_sel_w)] == $past(bsr_val_w)))
    else $error("port C shadow not updated");
  AST_READ_DATA: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    ($rose(dev_rd_n_out) && (dev_addr_w != ppio_pkg::DEV_CTRL)) |->
    (rdata_w == $past(dbus_sync_w, 2))) else $error("read byte not captured");
  AST_DONE_STICKY: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    done_w |=> done_r) else $error("done flag lost");
endmodule

// File: tb/ppio_dev_model.sv
// Purpose: behavioural parallel_io_device for the host bench
// Assumes: mode 0 ports, group B strobed output, fixed input patterns
// Notes: released data bus shows the inverse of the last read byte
`timescale 1ns/1ps
module ppio_dev_model #(
  parameter logic [7:0] IN_A = 8'h5A,
  parameter logic [7:0] IN_B = 8'hC3,
  parameter logic [7:0] IN_C = 8'h96
) (
  input wire logic rst_in, // reset, active high
  input wire logic cs_n_in, // chip select
  input wire logic rd_n_in, // read strobe
  input wire logic wr_n_in, // write strobe
  input wire logic [1:0] a_in, // address select
  input wire logic [7:0] d_in, // bus level
  output logic [7:0] d_out, // bus as left by us
  output logic irq_a_out, // group A request, PC3
  output logic irq_b_out // group B request, PC0
);
  logic [7:0] ctrl_r, lat_a, lat_b, lat_c, rdval;
  logic [7:0] last_r = 8'h00;
  logic [3:0] dir_r; // A, Cup, B, Clow; 1 = input
  logic rd_sel;
  int ctl_reads = 0;
  logic m1_b_r = 1'b0; // group B in strobed mode
  logic obf_b_n = 1'b1; // group B output-buffer-full, active low
  logic interrupt_request_b = 1'b0; // group B request
  logic ack_n = 1'b1; // peripheral acknowledge, active low
  assign rd_sel = !cs_n_in && !rd_n_in && a_in != 2'h3;
  always_comb begin
    case (a_in)
      2'h0: rdval = dir_r[3] ? IN_A : lat_a;
      2'h1: rdval = dir_r[1] ? IN_B : lat_b;
      default: rdval = {dir_r[2] ? IN_C[7:4] : lat_c[7:4], dir_r[0] ? IN_C[3:0] : lat_c[3:0]};
    endcase
    // strobed group B: line 1 buffer-full, line 0 request
    if (m1_b_r && a_in == 2'h2) rdval[1:0] = {obf_b_n, interrupt_request_b};
  end
  // no pull-ups: a floating bus must not look like the last byte
  assign d_out = rd_sel ? rdval : ~last_r;
  assign irq_a_out = lat_c[3];
  assign irq_b_out = m1_b_r ? interrupt_request_b : lat_c[0];
  always @(posedge rd_n_in) begin
    if (!cs_n_in) begin
      last_r <= rdval;
      if (a_in == 2'h3) ctl_reads++;
    end
  end
  always @(posedge wr_n_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= 8'h00;
      dir_r <= 4'hF;
      lat_a <= 8'h00;
      lat_b <= 8'h00;
      lat_c <= 8'h00;
      m1_b_r <= 1'b0;
      obf_b_n <= 1'b1;
      interrupt_request_b <= 1'b0;
    end else if (!cs_n_in) begin
      case (a_in)
        2'h0: lat_a <= d_in;
        2'h1: begin
          lat_b <= d_in;
          if (m1_b_r) obf_b_n <= 1'b0;
        end
        2'h2: lat_c <= d_in;
        default: begin
          ctrl_r <= d_in;
          if (d_in[7]) begin
            dir_r <= {d_in[4], d_in[3], d_in[1], d_in[0]};
            m1_b_r <= d_in[2];
            lat_a <= 8'h00;
            lat_b <= 8'h00;
            lat_c <= 8'h00;
          end else begin
            lat_c[d_in[3:1]] <= d_in[0];
          end
        end
      endcase
    end
  end
  always @(negedge wr_n_in) begin
    if (!cs_n_in && a_in == 2'h1) interrupt_request_b <= 1'b0;
  end
  // peripheral takes each byte a while later, off the clock edge
  always @(negedge obf_b_n) begin
    #410 ack_n = 1'b0;
    #200 ack_n = 1'b1;
  end
  always @(negedge ack_n) begin
    obf_b_n <= 1'b1;
  end
  always @(posedge ack_n) begin
    if (lat_c[2]) interrupt_request_b <= 1'b1;
  end
endmodule

// File: tb/ppio_host_ctrl_tb_top.sv
// Purpose: self-checking bench for the parallel-io host controller
// Assumes: one device model on the pins, bench is the AHB master
// Notes: hready loops back from hreadyout as on a one-slave bus
`timescale 1ns/1ps
module ppio_host_ctrl_tb_top;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, cs_n, rd_n, wr_n, a_lo, a_hi, oe, dev_rst, irq_a, irq_b;
  logic [31:0] hrdata;
  logic [7:0] d_drv, d_dev, d_bus;
  int fails = 0;
  int num_checks = 0;
  assign d_bus = oe ? d_drv : d_dev;
  always #25 clk_sys_in = ~clk_sys_in;
  ppio_host_ctrl i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
    .hresp_out(hresp), .dev_cs_n_out(cs_n), .dev_rd_n_out(rd_n), .dev_wr_n_out(wr_n),
    .addr_sel_lo_out(a_lo), .addr_sel_hi_out(a_hi), .dev_data_in(d_bus),
    .dev_data_out(d_drv), .dev_data_oe_out(oe), .dev_reset_out(dev_rst),
    .irq_a_in(irq_a), .irq_b_in(irq_b));
  ppio_dev_model i_dev (.rst_in(dev_rst), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .a_in({a_hi, a_lo}), .d_in(d_bus), .d_out(d_dev), .irq_a_out(irq_a), .irq_b_out(irq_b));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_done;
    logic [31:0] q;
    int n;
    q = 32'h0;
    for (n = 0; n < 200 && q[ppio_pkg::ST_DONE] !== 1'b1; n++) rd(ppio_pkg::REG_STAT, q);
    check(32'(q[ppio_pkg::ST_DONE]), 32'h1, "cycle done");
    wr(ppio_pkg::REG_STAT, 32'h2);
  endtask
  task automatic op(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    wait_done();
  endtask
  task automatic t_after_reset;
    logic [31:0] q;
    rd(ppio_pkg::REG_CTL, q);
    check(q, 32'h0, "ctl");
    rd(8'h40, q);
    check(q, 32'h0, "unmapped");
    rd(ppio_pkg::REG_STAT, q);
    check(q, 32'h0, "stat after reset");
    check(32'(hresp), 32'h0, "okay response");
    check(32'(i_dev.dir_r), 32'hF, "all ports input");
  endtask
  task automatic t_mode0;
    logic [31:0] q;
    logic [7:0] ex [3];
    int i;
    op(ppio_pkg::REG_MODE, 32'h12);
    check(32'(i_dev.ctrl_r), 32'h92, "mode word");
    check(32'(i_dev.dir_r), 32'hA, "dirs");
    rd(ppio_pkg::REG_STAT, q);
    check(32'(q[11:8]), 32'hA, "stat dirs");
    check(32'(q[ppio_pkg::ST_MODE_VALID]), 32'h1, "mode valid");
    rd(ppio_pkg::REG_MODE, q);
    check(32'(q[6:0]), 32'h12, "mode shadow");
    op(ppio_pkg::REG_CMD, 32'h023C);
    ex = '{8'h5A, 8'hC3, 8'h3C};
    for (i = 0; i < 3; i++) begin
      op(ppio_pkg::REG_CMD, 32'h1000 | (i << 8));
      rd(ppio_pkg::REG_RDATA, q);
      check(32'(q[7:0]), 32'(ex[i]), "port read");
    end
    op(ppio_pkg::REG_MODE, 32'h00);
    ex = '{8'hA5, 8'h69, 8'hE1};
    for (i = 0; i < 3; i++) op(ppio_pkg::REG_CMD, 32'(ex[i]) | (i << 8));
    for (i = 0; i < 3; i++) begin
      op(ppio_pkg::REG_CMD, 32'h1000 | (i << 8));
      rd(ppio_pkg::REG_RDATA, q);
      check(32'(q[7:0]), 32'(ex[i]), "latched out");
    end
  endtask
  task automatic t_bsr;
    logic [31:0] q;
    int b;
    for (b = 0; b < 8; b++) begin
      op(ppio_pkg::REG_BSR, 32'h8 | b);
      check(32'(i_dev.lat_c[b]), 32'h1, "bit set");
    end
    rd(ppio_pkg::REG_STAT, q);
    check(32'(q[5:4]), 32'h3, "irq pins seen");
    check(32'(q[14:12]), 32'h7, "interrupt_enable_flag flags");
    rd(ppio_pkg::REG_RDATA, q);
    check(32'(q[15:8]), 32'hFF, "c shadow set");
    for (b = 0; b < 8; b++) op(ppio_pkg::REG_BSR, b);
    check(32'(i_dev.lat_c), 32'h0, "bits cleared");
    check(32'(i_dev.ctrl_r), 32'h0E, "bsr word");
    rd(ppio_pkg::REG_RDATA, q);
    check(32'(q[15:8]), 32'h0, "c shadow");
  endtask
  task automatic t_mode1;
    logic [31:0] q;
    op(ppio_pkg::REG_MODE, 32'h04);
    op(ppio_pkg::REG_BSR, 32'hA);
    wr(ppio_pkg::REG_CMD, 32'h0155);
    repeat (12) @(posedge clk_sys_in);
    check(32'(i_dev.obf_b_n), 32'h0, "buffer full");
    wait_done();
    repeat (20) @(posedge clk_sys_in);
    rd(ppio_pkg::REG_STAT, q);
    check(32'(q[5]), 32'h1, "out request");
    op(ppio_pkg::REG_CMD, 32'h1200);
    rd(ppio_pkg::REG_RDATA, q);
    check(32'(q[7:0]), 32'h07, "c status");
    wr(ppio_pkg::REG_CMD, 32'h01AA);
    repeat (6) @(posedge clk_sys_in);
    rd(ppio_pkg::REG_STAT, q);
    check(32'(q[5]), 32'h0, "request cleared");
    wait_done();
    repeat (20) @(posedge clk_sys_in);
  endtask
  task automatic t_refuse;
    logic [31:0] q;
    wr(ppio_pkg::REG_CMD, 32'h1300);
    rd(ppio_pkg::REG_STAT, q);
    check(32'(q[2:0]), 32'h4, "ctl read refused");
    check(32'(i_dev.ctl_reads), 32'h0, "no ctl read");
    wr(ppio_pkg::REG_STAT, 32'h4);
    wr(ppio_pkg::REG_CMD, 32'h0111);
    repeat (2) @(posedge clk_sys_in);
    wr(ppio_pkg::REG_CMD, 32'h0122);
    wait_done();
    rd(ppio_pkg::REG_STAT, q);
    check(32'(q[2]), 32'h1, "busy refusal");
    check(32'(i_dev.lat_b), 32'h11, "first write kept");
  endtask
  task automatic t_dev_reset;
    wr(ppio_pkg::REG_CTL, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    check(32'({dev_rst, cs_n, oe}), 32'h6, "reset pins");
    check(32'({i_dev.dir_r, i_dev.lat_a}), 32'hF00, "ports cleared");
    wr(ppio_pkg::REG_CTL, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    check(32'(dev_rst), 32'h0, "reset released");
  endtask
  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    check(32'({dev_rst, cs_n, rd_n, wr_n, oe}), 32'h1E, "pins in reset");
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_after_reset();
    t_mode0();
    t_bsr();
    t_mode1();
    t_refuse();
    t_dev_reset();
    results();
  end
endmodule
